/* src/cgc_defines.svh */
// Register offsets, field positions, reset values and widths of the global clock block.
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH
`define CGC_ADDR_W 4
`define CGC_OFS_IRQ_ENABLE 4'h0
`define CGC_OFS_CLOCK_SELECT 4'h1
`define CGC_OFS_IRQ_STATUS 4'h2
`define CGC_OFS_IRQ_CLEAR 4'h3
`define CGC_OFS_IRQ_MASK 4'h4
`define CGC_OFS_GLOBAL_STATE 4'h5
`define CGC_IE_RD_BAD_WRITE 2
`define CGC_IE_RD_BAD_ADDR 1
`define CGC_IE_WR_SET_BAD_WRITE 10
`define CGC_IE_WR_SET_BAD_ADDR 9
`define CGC_IE_WR_CLR_BAD_WRITE 2
`define CGC_IE_WR_CLR_BAD_ADDR 1
`define CGC_IE_RD_FIXED 16'h0A00
`define CGC_IE_RST_EN 1'b0
`define CGC_CS_RESET 16'h7F05
`define CGC_CS_PRESCALE_HI 15
`define CGC_CS_PRESCALE_LO 8
`define CGC_CS_SOURCE_HI 7
`define CGC_CS_SOURCE_LO 6
`define CGC_CS_ZERO_BIT 4
`define CGC_CS_MEMDIV_HI 3
`define CGC_CS_MEMDIV_LO 0
`define CGC_CS_WMASK 16'hFFCF
`define CGC_EV_BAD_WRITE 0
`define CGC_EV_BAD_ADDR 1
`define CGC_NUM_EV 2
`endif

/* src/cgc_pkg.sv */
// Types shared by the global clock select block.
package cgc_pkg;
    // Event vector type, one bit for each of the two global error events.
    typedef logic [1:0] cgc_ev_t;
endpackage : cgc_pkg

/* src/cgc_divider.sv */
// Programmable divider that turns an input enable into a slower enable pulse.
`include "cgc_defines.svh"
module cgc_divider
    import cgc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic [WIDTH-1:0] i_ratio,
    output logic o_tick
);
    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("cgc_divider WIDTH out of range");
        end
    end

    // Whole state of the divider.
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic tick;
    } cgc_div_state_t;

    cgc_div_state_t state;
    cgc_div_state_t next_state;

    // Count input ticks; emit one tick each ratio+1 input ticks.
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (i_tick) begin
            if (state.count >= i_ratio) begin
                // Using >= lets a ratio lowered mid-count end the period at once.
                next_state.count = '0;
                next_state.tick = 1'b1;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_tick = state.tick;
endmodule : cgc_divider

/* src/cgc_global_clock.sv */
// Global interrupt enable and clock chain select registers with their dividers.
`include "cgc_defines.svh"

// Overview of operation
// - Set 1 clear 0 sets; reverse clears enable.
// - Write bits 10,9 set; 2,1 clear.
// - Read bit 2: bad write interrupt enable.
// - Read bit 1: bad address interrupt enable.
// - Both registers accessed as 16-bit words.
// - Prescaler bits 15:8 divide timer source by n+1.
// - Prescaler resets to 127, dividing by 128.
// - Bits 7:6 divide memory clock by 2..16.
// - Bits 3:0 divide memory source by n+1.
// - global_op_state reads 1 when module access enabled.
module cgc_global_clock
    import cgc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [`CGC_ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_mem_src_tick,
    input wire logic i_global_op_state,
    input wire logic i_bad_write_event,
    input wire logic i_bad_addr_event,
    output logic o_mem_clk_tick,
    output logic o_timer_src_tick,
    output logic o_timer_sys_tick,
    output logic o_bad_write_irq,
    output logic o_bad_addr_irq,
    output logic o_irq,
    output logic o_write_refused
);
    // The register file is built for 16-bit words only.
    initial begin
        if (DATA_W != 16) begin
            $error("cgc_global_clock DATA_W must be 16");
        end
    end

    // Whole state of the block.
    typedef struct packed {
        logic bad_write_irq_en;  // Enable of the invalid write interrupt.
        logic bad_addr_irq_en;  // Enable of the bad address interrupt.
        logic [15:0] clock_select_reg;  // Clock chain selection word.
        cgc_ev_t irq_status;  // Sticky event flags.
        cgc_ev_t irq_mask;  // Enables onto the shared interrupt line.
        logic [3:0] src_count;  // Fixed divide-by-2..16 counter.
        logic timer_src_tick;  // Registered timer source enable.
        logic bad_write_irq;  // Registered request toward the processor.
        logic bad_addr_irq;  // Registered request toward the processor.
        logic write_refused;  // Sticky: a clock select write was blocked.
        logic [15:0] rdata;  // Read data, valid one cycle after the strobe.
    } cgc_state_t;

    cgc_state_t state;
    cgc_state_t next_state;

    logic mem_clk_tick;  // Memory controller clock enable from the first divider.
    logic timer_sys_tick;  // Timer system clock enable from the prescaler.
    logic [3:0] src_limit;  // Terminal count of the fixed divider.
    cgc_ev_t events;  // Raw events this cycle.
    logic [15:0] ie_read;  // Read view of the enable register.

    // Memory controller clock: source divided by n+1.
    cgc_divider #(
        .WIDTH(4)
    ) u_mem_div (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_tick(i_mem_src_tick),
        .i_ratio(state.clock_select_reg[`CGC_CS_MEMDIV_HI:`CGC_CS_MEMDIV_LO]),
        .o_tick(mem_clk_tick)
    );

    // Timer system clock: timer source divided by n+1.
    cgc_divider #(
        .WIDTH(8)
    ) u_prescale (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_tick(state.timer_src_tick),
        .i_ratio(state.clock_select_reg[`CGC_CS_PRESCALE_HI:`CGC_CS_PRESCALE_LO]),
        .o_tick(timer_sys_tick)
    );

    // Event vector assembly.
    always_comb begin
        events = '0;
        events[`CGC_EV_BAD_WRITE] = i_bad_write_event;
        events[`CGC_EV_BAD_ADDR] = i_bad_addr_event;
    end

    // Fixed divider terminal count: codes 0..3 give 2,4,8,16, so limit is 2^(code+1)-1.
    always_comb begin
        unique case (state.clock_select_reg[`CGC_CS_SOURCE_HI:`CGC_CS_SOURCE_LO])
            2'h0: src_limit = 4'h1;
            2'h1: src_limit = 4'h3;
            2'h2: src_limit = 4'h7;
            2'h3: src_limit = 4'hF;
        endcase
    end

    // Read view: fixed pattern plus the two live enables.
    always_comb begin
        ie_read = `CGC_IE_RD_FIXED;
        ie_read[`CGC_IE_RD_BAD_WRITE] = state.bad_write_irq_en;
        ie_read[`CGC_IE_RD_BAD_ADDR] = state.bad_addr_irq_en;
    end

    // Next-state logic for registers, dividers and interrupts.
    always_comb begin
        next_state = state;
        next_state.rdata = '0;
        next_state.timer_src_tick = 1'b0;
        // Fixed divider advances on each memory clock enable.
        if (mem_clk_tick) begin
            if (state.src_count >= src_limit) begin
                next_state.src_count = '0;
                next_state.timer_src_tick = 1'b1;
            end else begin
                next_state.src_count = state.src_count + 4'h1;
            end
        end
        // Register writes, whole 16-bit words.
        if (i_wr) begin
            unique case (i_addr)
                `CGC_OFS_IRQ_ENABLE: begin
                    // Paired set/clear; equal pairs leave the bit alone.
                    if (i_wdata[`CGC_IE_WR_SET_BAD_WRITE]
                        && !i_wdata[`CGC_IE_WR_CLR_BAD_WRITE]) begin
                        next_state.bad_write_irq_en = 1'b1;
                    end else if (!i_wdata[`CGC_IE_WR_SET_BAD_WRITE]
                        && i_wdata[`CGC_IE_WR_CLR_BAD_WRITE]) begin
                        next_state.bad_write_irq_en = 1'b0;
                    end
                    if (i_wdata[`CGC_IE_WR_SET_BAD_ADDR]
                        && !i_wdata[`CGC_IE_WR_CLR_BAD_ADDR]) begin
                        next_state.bad_addr_irq_en = 1'b1;
                    end else if (!i_wdata[`CGC_IE_WR_SET_BAD_ADDR]
                        && i_wdata[`CGC_IE_WR_CLR_BAD_ADDR]) begin
                        next_state.bad_addr_irq_en = 1'b0;
                    end
                end
                `CGC_OFS_CLOCK_SELECT: begin
                    // Changing dividers under a running module would glitch its clocks,
                    // so the write is dropped and flagged instead.
                    if (i_global_op_state) begin
                        next_state.write_refused = 1'b1;
                    end else begin
                        // Bits 5 and 4 always hold zero.
                        next_state.clock_select_reg = i_wdata & `CGC_CS_WMASK;
                    end
                end
                `CGC_OFS_IRQ_CLEAR: begin
                    next_state.irq_status = state.irq_status & ~i_wdata[1:0];
                    next_state.write_refused = state.write_refused & ~i_wdata[2];
                end
                `CGC_OFS_IRQ_MASK: begin
                    next_state.irq_mask = i_wdata[1:0];
                end
                default: begin
                    // Read-only or unmapped offsets ignore writes.
                end
            endcase
        end
        // Events set sticky flags after the clear so the set wins.
        next_state.irq_status = next_state.irq_status | events;
        // Requests only while the matching enable is set.
        next_state.bad_write_irq = i_bad_write_event && state.bad_write_irq_en;
        next_state.bad_addr_irq = i_bad_addr_event && state.bad_addr_irq_en;
        // Read data appear in the cycle after the strobe.
        if (i_rd) begin
            unique case (i_addr)
                `CGC_OFS_IRQ_ENABLE: next_state.rdata = ie_read;
                `CGC_OFS_CLOCK_SELECT: next_state.rdata = state.clock_select_reg;
                `CGC_OFS_IRQ_STATUS: next_state.rdata = {14'h0000, state.irq_status};
                `CGC_OFS_IRQ_MASK: next_state.rdata = {14'h0000, state.irq_mask};
                `CGC_OFS_GLOBAL_STATE: begin
                    next_state.rdata = {14'h0000, state.write_refused, i_global_op_state};
                end
                default: next_state.rdata = 16'h0000;
            endcase
        end
    end

    // State register with documented reset values.
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
            state.bad_write_irq_en <= `CGC_IE_RST_EN;
            state.bad_addr_irq_en <= `CGC_IE_RST_EN;
            state.clock_select_reg <= `CGC_CS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_mem_clk_tick = mem_clk_tick;
    assign o_timer_src_tick = state.timer_src_tick;
    assign o_timer_sys_tick = timer_sys_tick;
    assign o_bad_write_irq = state.bad_write_irq;
    assign o_bad_addr_irq = state.bad_addr_irq;
    assign o_irq = |(state.irq_status & state.irq_mask);
    assign o_write_refused = state.write_refused;
endmodule : cgc_global_clock

/* dv/cgc_global_clock_checker.sv */
// Port-level checker for the global clock select block.
`include "cgc_defines.svh"
module cgc_global_clock_checker
    import cgc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [`CGC_ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic i_mem_src_tick,
    input wire logic i_global_op_state,
    input wire logic i_bad_write_event,
    input wire logic i_bad_addr_event,
    input wire logic o_mem_clk_tick,
    input wire logic o_timer_src_tick,
    input wire logic o_timer_sys_tick,
    input wire logic o_bad_write_irq,
    input wire logic o_bad_addr_irq,
    input wire logic o_irq,
    input wire logic o_write_refused
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks live in the core clock domain.
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_ie_layout: assert property (i_rd && i_addr == 4'h0
        |=> o_rdata[15:3] == 13'h0140 && !o_rdata[0]) else $error("enable layout wrong");
    a_ie_set: assert property (i_wr && i_addr == 4'h0 && i_wdata[9] && !i_wdata[1]
        ##1 i_rd && i_addr == 4'h0 |=> o_rdata[1]) else $error("enable not set");
    a_ie_clear: assert property (i_wr && i_addr == 4'h0 && i_wdata[2] && !i_wdata[10]
        ##1 i_rd && i_addr == 4'h0 |=> !o_rdata[2]) else $error("enable not cleared");
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside read slot");
    a_state_read: assert property (i_rd && i_addr == 4'h5
        |=> o_rdata[0] == $past(i_global_op_state)) else $error("state bit wrong");
    a_irq_cause: assert property (o_bad_addr_irq |-> $past(i_bad_addr_event))
        else $error("irq without event");
    a_mem_cause: assert property (o_mem_clk_tick |-> $past(i_mem_src_tick))
        else $error("memory tick without source");
    a_src_gap: assert property (o_timer_src_tick |=> !o_timer_src_tick)
        else $error("timer source ticks adjacent");
    a_sys_cause: assert property (o_timer_sys_tick |-> $past(o_timer_src_tick))
        else $error("system tick without source");
    // Main scenarios seen at least once.
    c_sys: cover property (o_timer_sys_tick);
    c_irq: cover property (o_irq);
    c_refused: cover property (o_write_refused);
endmodule : cgc_global_clock_checker

bind cgc_global_clock cgc_global_clock_checker #(.DATA_W(DATA_W)) u_cgc_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_src_tick(i_mem_src_tick),
    .i_global_op_state(i_global_op_state), .i_bad_write_event(i_bad_write_event),
    .i_bad_addr_event(i_bad_addr_event), .o_mem_clk_tick(o_mem_clk_tick),
    .o_timer_src_tick(o_timer_src_tick), .o_timer_sys_tick(o_timer_sys_tick),
    .o_bad_write_irq(o_bad_write_irq), .o_bad_addr_irq(o_bad_addr_irq), .o_irq(o_irq),
    .o_write_refused(o_write_refused));

/* dv/cgc_global_clock_tb.sv */
// Self-checking bench for the global clock select block.
`include "cgc_defines.svh"
module cgc_global_clock_tb import cgc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0, i_rd = 1'b0, i_mem_src_tick = 1'b1, i_global_op_state = 1'b0;
    logic i_bad_write_event = 1'b0, i_bad_addr_event = 1'b0;
    logic [15:0] o_rdata;
    logic o_mem_clk_tick, o_timer_src_tick, o_timer_sys_tick, o_bad_write_irq, o_bad_addr_irq;
    logic o_irq;
    logic o_write_refused; // Sticky flag of a blocked clock select write.
    int n_errors = 0;
    int checks_done = 0;
    logic [1:0] m_en = 2'h0; // Model enables: bit 1 bad write, bit 0 bad address.
    logic [15:0] m_cs = 16'h7F05; // Model of the clock select register.
    logic [15:0] d;
    logic [3:0] r;
    // Free-running core clock at 125 MHz.
    always #4 i_core_clk = ~i_core_clk;
    cgc_global_clock uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_mem_src_tick(i_mem_src_tick), .i_global_op_state(i_global_op_state),
        .i_bad_write_event(i_bad_write_event), .i_bad_addr_event(i_bad_addr_event),
        .o_mem_clk_tick(o_mem_clk_tick), .o_timer_src_tick(o_timer_src_tick),
        .o_timer_sys_tick(o_timer_sys_tick), .o_bad_write_irq(o_bad_write_irq),
        .o_bad_addr_irq(o_bad_addr_irq), .o_irq(o_irq), .o_write_refused(o_write_refused));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle write strobe; the slave never stalls; enable writes are always paired.
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    // Read data are only valid in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd
    function automatic logic tk(input int k);
        return (k == 0) ? o_mem_clk_tick : (k == 1) ? o_timer_src_tick : o_timer_sys_tick;
    endfunction : tk
    // Measure between the second and third tick, since the first may carry the old phase.
    task automatic period(input int k, input int exp);
        int n;
        int t;
        n = 0;
        t = 0;
        while (t < 3 && n < 5000) begin
            @(posedge i_core_clk);
            #1 n++;
            if (tk(k) === 1'b1) begin
                t++;
                if (t == 2) n = 0;
            end
        end
        chk(16'(n), 16'(exp));
    endtask : period
    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // Watchdog cuts a hang well beyond the expected run length.
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(53));
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(`CGC_OFS_IRQ_ENABLE, 16'h0A00);
        rd(`CGC_OFS_CLOCK_SELECT, 16'h7F05);
        rd(4'h9, 16'h0000);
        // 24 random set/clear pairings.
        for (int j = 0; j < 24; j++) begin
            r = 4'($urandom);
            d = {5'h00, r[3:2], 6'h00, r[1:0], 1'b0};
            wr(`CGC_OFS_IRQ_ENABLE, d);
            for (int b = 0; b < 2; b++) begin
                if (d[9+b] && !d[1+b]) m_en[b] = 1'b1;
                else if (!d[9+b] && d[1+b]) m_en[b] = 1'b0;
            end
            rd(`CGC_OFS_IRQ_ENABLE, 16'h0A00 | {13'h0000, m_en, 1'b0});
        end
        // Software keeps bit 4 at zero; the memory source enable is held high, ticking every 125 MHz core cycle.
        for (int j = 0; j < 8; j++) begin
            m_cs = 16'($urandom) & `CGC_CS_WMASK;
            wr(`CGC_OFS_CLOCK_SELECT, m_cs);
            rd(`CGC_OFS_CLOCK_SELECT, m_cs);
        end
        i_global_op_state <= 1'b1;
        wr(`CGC_OFS_CLOCK_SELECT, 16'h0000);
        rd(`CGC_OFS_CLOCK_SELECT, m_cs);
        chk({15'h0000, o_write_refused}, 16'h0001);
        rd(`CGC_OFS_GLOBAL_STATE, 16'h0003);
        i_global_op_state <= 1'b0;
        wr(`CGC_OFS_IRQ_CLEAR, 16'h0004);
        rd(`CGC_OFS_GLOBAL_STATE, 16'h0000);
        chk({15'h0000, o_write_refused}, 16'h0000);
        // Divider chain at the extremes of each field.
        for (int j = 0; j < 4; j++) begin
            d = {8'((j == 0) ? 255 : j - 1), 2'(j), 2'b00, 4'(j * 5)};
            wr(`CGC_OFS_CLOCK_SELECT, d);
            period(0, j * 5 + 1);
            period(1, (j * 5 + 1) << (j + 1));
            period(2, ((j * 5 + 1) << (j + 1)) * (d[15:8] + 1));
        end
        // Both events under every enable pattern and a random mask.
        for (int j = 0; j < 4; j++) begin
            r = 4'($urandom);
            wr(`CGC_OFS_IRQ_ENABLE, {5'h00, 2'(j), 6'h00, ~2'(j), 1'b0});
            m_en = 2'(j);
            wr(`CGC_OFS_IRQ_MASK, {14'h0000, r[1:0]});
            @(posedge i_core_clk);
            {i_bad_write_event, i_bad_addr_event} <= 2'b11;
            @(posedge i_core_clk);
            {i_bad_write_event, i_bad_addr_event} <= 2'b00;
            #1 chk({14'h0000, o_bad_write_irq, o_bad_addr_irq}, {14'h0000, m_en});
            rd(`CGC_OFS_IRQ_STATUS, 16'h0003);
            chk({15'h0000, o_irq}, {15'h0000, |r[1:0]});
            wr(`CGC_OFS_IRQ_CLEAR, 16'h0003);
            rd(`CGC_OFS_IRQ_STATUS, 16'h0000);
            chk({15'h0000, o_irq}, 16'h0000);
        end
        print_verdict();
    end
endmodule : cgc_global_clock_tb
